/* verification/pcc_xtal_model.sv */
// Watch crystal model that can be stopped to mimic a lost crystal.
`timescale 1ns/1ns
module pcc_xtal_model (
    input wire logic run,
    output logic xtal
);
    // Half of one 32.768 kHz period; a stopped crystal parks the level low.
    initial begin
        xtal = 1'b0;
        forever begin
            #15259;
            xtal = run ? ~xtal : 1'b0;
        end
    end
endmodule

/* verification/tb_pcc_clock_control.sv */
// Self-checking bench for the core clock control block.
`timescale 1ns/1ns
module tb_pcc_clock_control import pcc_pkg::*; ();
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] sfr_rdata;
    logic xtal_in;
    logic ext_access_n = 1'b0;
    logic int_service = 1'b0;
    logic power_down = 1'b0;
    logic xtal_run = 1'b1;
    logic pll_tick;
    logic core_tick;
    logic mod_tick;
    logic osc_run;
    logic [7:0] rd;
    int fails = 0;
    int num_checks = 0;
    int cycles = 0;
    int np;
    int nc;
    int nm;

    always #20 mclk = ~mclk;

    pcc_xtal_model xtal_m (.run(xtal_run), .xtal(xtal_in));

    pcc_clock_control dut (.mclk(mclk), .srst(srst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .xtal_in(xtal_in),
        .external_access_pin_n(ext_access_n), .int_service(int_service), .power_down(power_down),
        .pll_tick(pll_tick), .core_tick(core_tick), .mod_tick(mod_tick), .osc_run(osc_run));

    ////////////////////////////////////////////////////////////////////////////////////
    task test_done;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // The run is cut short well beyond the expected length.
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            fails = fails + 1;
            test_done();
        end
    end

    task chk8(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task chkn(input int got, input int exp, input int tol);
        num_checks++;
        if (got < exp - tol || got > exp + tol) begin
            fails++;
            $display("CHECK FAILED at %0t: count %0d expected %0d", $time, got, exp);
        end
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge mclk);
        sfr_wr <= 1'b0;
    endtask

    task rdr(input logic [7:0] a);
        @(posedge mclk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge mclk);
        sfr_rd <= 1'b0;
        @(posedge mclk);
        rd = sfr_rdata;
    endtask

    // Counts loop, core and modulator ticks over a number of cycles.
    task win(input int n);
        np = 0;
        nc = 0;
        nm = 0;
        repeat (n) begin
            @(posedge mclk);
            np += int'(pll_tick === 1'b1);
            nc += int'(core_tick === 1'b1);
            nm += int'(mod_tick === 1'b1);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge mclk);
        srst <= 1'b0;
        rdr(PCC_CTRL_ADDR);
        chk8(rd, 8'h03);
        wr(PCC_CTRL_ADDR, 8'h53);
        rdr(PCC_CTRL_ADDR);
        chk8(rd, 8'h03);
        rdr(8'h00);
        chk8(rd, 8'h00);
        win(7630);
        chkn(np, int'(7630 * PCC_PLL_HZ / PCC_MCLK_HZ), 2);
        chkn(nc, np >> 3, 2);
        chkn(nm, int'(7630 * PCC_XTAL_HZ / PCC_MCLK_HZ), 1);
        $display("reset and rate test done");
        for (int d = 0; d < 8; d++) begin
            wr(PCC_CTRL_ADDR, 8'(d));
            win(2048);
            chkn(nc, np >> d, 2);
        end
        $display("divider test done");
        rdr(PCC_CTRL_ADDR);
        chk8(rd & 8'h40, 8'h40);
        wr(PCC_CTRL_ADDR, 8'hff);
        rdr(PCC_CTRL_ADDR);
        chk8(rd, 8'hcf);
        power_down <= 1'b1;
        repeat (3) @(posedge mclk);
        chk8({7'h00, osc_run}, 8'h00);
        wr(PCC_CTRL_ADDR, 8'h0f);
        repeat (3) @(posedge mclk);
        chk8({7'h00, osc_run}, 8'h01);
        power_down <= 1'b0;
        $display("register and power-down test done");
        wr(PCC_CTRL_ADDR, 8'h0b);
        int_service <= 1'b1;
        win(2048);
        chkn(nc, np, 2);
        int_service <= 1'b0;
        win(2048);
        chkn(nc, np >> 3, 2);
        wr(PCC_CTRL_ADDR, 8'h03);
        int_service <= 1'b1;
        win(2048);
        chkn(nc, np >> 3, 2);
        int_service <= 1'b0;
        $display("fast interrupt test done");
        xtal_run <= 1'b0;
        repeat (2500) @(posedge mclk);
        win(500);
        chkn(np + nc, 0, 0);
        rdr(PCC_CTRL_ADDR);
        chk8(rd & 8'h40, 8'h00);
        $display("crystal loss test done");
        srst <= 1'b1;
        ext_access_n <= 1'b1;
        xtal_run <= 1'b1;
        repeat (3) @(posedge mclk);
        srst <= 1'b0;
        rdr(PCC_CTRL_ADDR);
        chk8(rd, 8'h13);
        ext_access_n <= 1'b0;
        repeat (4) @(posedge mclk);
        rdr(PCC_CTRL_ADDR);
        chk8(rd, 8'h13);
        $display("pin latch test done");
        test_done();
    end
endmodule

/* verilog/pcc_clock_control.sv */
// Loop clock, core divider, lock status and clock control register.
`timescale 1ns/1ns
module pcc_clock_control import pcc_pkg::*; (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic xtal_in,
    input wire logic external_access_pin_n,
    input wire logic int_service,
    input wire logic power_down,
    output logic pll_tick,
    output logic core_tick,
    output logic mod_tick,
    output logic osc_run
);

    logic xtal_meta_q;
    logic xtal_sync_q;
    logic xtal_prev_q;
    logic xtal_edge;
    logic ext_access_meta_q;
    logic ext_access_sync_q;
    logic capture_q;
    logic latched_external_access_q;
    logic oscillator_halt_in_sleep_q;
    logic fast_interrupt_clock_q;
    logic [PCC_CD_W-1:0] core_divider_q;
    logic [PCC_CD_W-1:0] eff_div;
    logic [PCC_PER_W-1:0] per_q;
    logic [2:0] good_q;
    logic period_ok;
    logic lock_bit;
    logic [PCC_NCO_W:0] nco_sum;
    logic [PCC_NCO_W-1:0] nco_q;
    logic ctrl_hit;
    logic [7:0] ctrl_value;
    pcc_lock_e lock_q;

    ////////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.
    always_ff @(posedge mclk) begin
        if (srst) begin
            xtal_meta_q <= 1'b0;
            xtal_sync_q <= 1'b0;
            xtal_prev_q <= 1'b0;
        end else begin
            xtal_meta_q <= xtal_in;
            xtal_sync_q <= xtal_meta_q;
            xtal_prev_q <= xtal_sync_q;
        end
    end

    assign xtal_edge = xtal_sync_q && !xtal_prev_q;

    // The pin stages run through reset so that the capture sees a settled level.
    always_ff @(posedge mclk) begin
        ext_access_meta_q <= external_access_pin_n;
        ext_access_sync_q <= ext_access_meta_q;
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // The pin level is caught in the cycle after reset releases and then held.
    always_ff @(posedge mclk) begin
        if (srst) begin
            capture_q <= 1'b1;
            latched_external_access_q <= 1'b0;
        end else begin
            capture_q <= 1'b0;
            if (capture_q) begin
                latched_external_access_q <= ext_access_sync_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Crystal period measurement and lock tracking.
    always_ff @(posedge mclk) begin
        if (srst || xtal_edge) begin
            per_q <= '0;
        end else if (per_q != PCC_LOSS_CYC) begin
            per_q <= per_q + 1'b1;
        end
    end

    assign period_ok = (per_q >= PCC_XTAL_PER_CYC - PCC_XTAL_TOL_CYC) &&
                       (per_q <= PCC_XTAL_PER_CYC + PCC_XTAL_TOL_CYC);

    always_ff @(posedge mclk) begin
        if (srst) begin
            lock_q <= PCC_ACQUIRE;
            good_q <= '0;
        end else begin
            case (lock_q)
                PCC_ACQUIRE: begin
                    if (xtal_edge) begin
                        good_q <= period_ok ? good_q + 1'b1 : 3'h0;
                        if (period_ok && good_q == PCC_LOCK_GOOD - 1'b1) begin
                            lock_q <= PCC_LOCKED;
                        end
                    end
                end
                PCC_LOCKED: begin
                    if (per_q == PCC_LOSS_CYC) begin
                        lock_q <= PCC_RAILED;
                    end
                end
                PCC_RAILED: begin
                    lock_q <= PCC_RAILED;
                end
                default: begin
                    lock_q <= PCC_ACQUIRE;
                end
            endcase
        end
    end

    assign lock_bit = (lock_q == PCC_LOCKED);

    ////////////////////////////////////////////////////////////////////////////////////
    // Loop output as a tick stream at the multiplied crystal rate.
    assign nco_sum = {1'b0, nco_q} + {1'b0, PCC_NCO_STEP};

    always_ff @(posedge mclk) begin
        if (srst) begin
            nco_q <= '0;
            pll_tick <= 1'b0;
        end else if (lock_q == PCC_RAILED) begin
            pll_tick <= 1'b0;
        end else begin
            nco_q <= nco_sum[PCC_NCO_W-1:0];
            pll_tick <= nco_sum[PCC_NCO_W];
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            mod_tick <= 1'b0;
        end else begin
            mod_tick <= xtal_edge;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            osc_run <= 1'b1;
        end else begin
            osc_run <= !(power_down && oscillator_halt_in_sleep_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Clock control register.
    assign ctrl_hit = (sfr_addr == PCC_CTRL_ADDR);

    always_ff @(posedge mclk) begin
        if (srst) begin
            oscillator_halt_in_sleep_q <= PCC_CTRL_RESET[PCC_OSC_HALT_BIT];
            fast_interrupt_clock_q <= PCC_CTRL_RESET[PCC_FAST_BIT];
            core_divider_q <= PCC_CD_RESET;
        end else if (sfr_wr && ctrl_hit) begin
            oscillator_halt_in_sleep_q <= sfr_wdata[PCC_OSC_HALT_BIT];
            fast_interrupt_clock_q <= sfr_wdata[PCC_FAST_BIT];
            core_divider_q <= sfr_wdata[PCC_CD_W-1:0];
        end
    end

    // Lock and latched pin bits come from status only, so writes leave them alone.
    always_comb begin
        ctrl_value = 8'h00;
        ctrl_value[PCC_OSC_HALT_BIT] = oscillator_halt_in_sleep_q;
        ctrl_value[PCC_LOCK_BIT] = lock_bit;
        ctrl_value[PCC_EXT_ACCESS_BIT] = latched_external_access_q;
        ctrl_value[PCC_FAST_BIT] = fast_interrupt_clock_q;
        ctrl_value[PCC_CD_W-1:0] = core_divider_q;
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd) begin
            sfr_rdata <= ctrl_hit ? ctrl_value : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Core clock enable.
    assign eff_div = (fast_interrupt_clock_q && int_service) ?
        PCC_CD_FASTEST : core_divider_q;

    pcc_core_divider u_div (
        .mclk(mclk),
        .srst(srst),
        .pll_tick(pll_tick),
        .div_sel(eff_div),
        .core_tick(core_tick)
    );

    ////////////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);

    a_loop_rate: assert property (
        lock_q != PCC_RAILED ##1 lock_q != PCC_RAILED |-> ##[0:2] pll_tick)
        else $error("Loop ticks too sparse.");
    a_reset_divider: assert property ($past(srst) |-> core_divider_q == PCC_CD_RESET)
        else $error("Divider not at reset value.");
    a_divider_write: assert property (
        sfr_wr && ctrl_hit |=> core_divider_q == $past(sfr_wdata[PCC_CD_W-1:0]))
        else $error("Divider field not written.");
    a_mod_follows: assert property (xtal_edge |=> mod_tick ##1 !mod_tick)
        else $error("Modulator tick not at crystal rate.");
    a_osc_halt: assert property (power_down && oscillator_halt_in_sleep_q |=> !osc_run)
        else $error("Oscillator not halted.");
    a_lock_read: assert property (
        sfr_rd && ctrl_hit |=> sfr_rdata[PCC_LOCK_BIT] == $past(lock_bit))
        else $error("Lock bit misread.");
    a_loss_rails: assert property (
        lock_q == PCC_LOCKED && per_q == PCC_LOSS_CYC
        |=> lock_q == PCC_RAILED ##1 !pll_tick ##1 !pll_tick && !core_tick)
        else $error("Loop did not rail on crystal loss.");
    a_pin_latch_held: assert property (
        !capture_q && !$past(srst) |=> $stable(latched_external_access_q))
        else $error("Latched pin bit moved.");
    a_fast_int: assert property (
        fast_interrupt_clock_q && int_service && pll_tick |=> core_tick)
        else $error("No fast override in interrupt.");
    a_no_override: assert property (!fast_interrupt_clock_q |-> eff_div == core_divider_q)
        else $error("Override without fast bit.");
    a_readonly_bits: assert property (
        sfr_wr && ctrl_hit && !capture_q && !xtal_edge && per_q != PCC_LOSS_CYC
        |=> $stable(latched_external_access_q) && $stable(lock_q))
        else $error("Status bit changed by write.");

    c_locked: cover property (lock_q == PCC_ACQUIRE ##1 lock_q == PCC_LOCKED);
    c_railed: cover property (lock_q == PCC_LOCKED ##1 lock_q == PCC_RAILED);
    c_fast: cover property (fast_interrupt_clock_q && int_service && core_divider_q == 3'h7);
    c_write: cover property (sfr_wr && ctrl_hit ##1 sfr_rd && ctrl_hit);

endmodule

/* verilog/pcc_core_divider.sv */
// Binary divider that turns loop ticks into core clock enables.
`timescale 1ns/1ns
module pcc_core_divider import pcc_pkg::*; #(
    parameter int CNT_W = PCC_DIV_CNT_W
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic pll_tick,
    input wire logic [PCC_CD_W-1:0] div_sel,
    output logic core_tick
);

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] mask;

    ////////////////////////////////////////////////////////////////////////////////////
    // The tick fires when the low field bits of the count are zero.
    assign mask = CNT_W'((8'h01 << div_sel) - 8'h01);

    always_ff @(posedge mclk) begin
        if (srst) begin
            cnt_q <= '0;
        end else if (pll_tick) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            core_tick <= 1'b0;
        end else begin
            core_tick <= pll_tick && ((cnt_q & mask) == '0);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);

    a_div_fastest: assert property (pll_tick && div_sel == PCC_CD_FASTEST |=> core_tick)
        else $error("Core tick missing at fastest setting.");
    a_div_only_on_pll: assert property (core_tick |-> $past(pll_tick))
        else $error("Core tick without loop tick.");

endmodule

/* verilog/pcc_pkg.sv */
// Shared constants for the core clock control block.
package pcc_pkg;

    ////////////////////////////////////////////////////////////////////////////////////
    localparam logic [7:0] PCC_CTRL_ADDR = 8'hd7;
    localparam logic [7:0] PCC_CTRL_RESET = 8'h03;
    localparam int PCC_OSC_HALT_BIT = 7;
    localparam int PCC_LOCK_BIT = 6;
    localparam int PCC_EXT_ACCESS_BIT = 4;
    localparam int PCC_FAST_BIT = 3;
    localparam int PCC_CD_W = 3;
    localparam logic [PCC_CD_W-1:0] PCC_CD_RESET = PCC_CTRL_RESET[PCC_CD_W-1:0];
    localparam logic [PCC_CD_W-1:0] PCC_CD_FASTEST = 3'h0;

    ////////////////////////////////////////////////////////////////////////////////////
    localparam longint PCC_MCLK_HZ = 25000000;
    localparam longint PCC_XTAL_HZ = 32768;
    localparam longint PCC_PLL_MULT = 384;
    localparam longint PCC_PLL_HZ = PCC_XTAL_HZ * PCC_PLL_MULT;
    localparam int PCC_NCO_W = 24;
    localparam logic [PCC_NCO_W-1:0] PCC_NCO_STEP =
        PCC_NCO_W'((PCC_PLL_HZ << PCC_NCO_W) / PCC_MCLK_HZ);
    localparam int PCC_PER_W = 11;
    localparam logic [PCC_PER_W-1:0] PCC_XTAL_PER_CYC = PCC_PER_W'(PCC_MCLK_HZ / PCC_XTAL_HZ);
    localparam logic [PCC_PER_W-1:0] PCC_XTAL_TOL_CYC = PCC_PER_W'(PCC_MCLK_HZ / PCC_XTAL_HZ / 8);
    localparam logic [PCC_PER_W-1:0] PCC_LOSS_CYC = PCC_PER_W'(2 * PCC_MCLK_HZ / PCC_XTAL_HZ);
    localparam logic [2:0] PCC_LOCK_GOOD = 3'h4;
    localparam int PCC_DIV_CNT_W = 7;

    typedef enum logic [1:0] {PCC_ACQUIRE, PCC_LOCKED, PCC_RAILED} pcc_lock_e;

endpackage
